// ==== hw/hpbp_pkg.sv ====
// Shared constants of the host parallel bus port
package hpbp_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int WADDR_W = ADDR_W - 1;
  localparam int SYNC_W = ADDR_W + DATA_W + 7;
  // Byte-lane masks towards the register fabric
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  // Level on interface_style_select for each handshake style
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_DATA_STROBE = 1'b1;
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    HPBP_IDLE = 2'h0,
    HPBP_RSTART = 2'h1,
    HPBP_READ = 2'h3,
    HPBP_WRITE = 2'h2
  } hpbp_state_t;
endpackage : hpbp_pkg

// ==== hw/hpbp_sync.sv ====
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module hpbp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : hpbp_sync

// ==== hw/hpbp_port.sv ====
// Host parallel bus port: pin handshake to internal register fabric
//
// Notes on behaviour
// [R1] Narrow mode: only low data byte used, upper byte never driven.
// [R2] Wide mode: all sixteen data lines driven and accepted, word transfers.
// [R3] Wide byte access: lane from address bit zero, lane enable, style; other floats.
// [R4] Host holds address strobe high while address sits on shared lines.
// [R5] Address captured at address strobe falling edge, held for whole access.
// [R6] Demultiplexed host ties address strobe to a fixed level.
// [R7] Ten address lines select exactly one register per access.
// [R8] Every register reachable by byte or word access.
// [R9] Host drives device select low for any access; high is ignored.
// [R10] Separate style, selected and read strobe low: addressed register driven out.
// [R11] Separate style, selected and write strobe low: addressed register loaded.
// [R12] Wide mode lane enable marks upper byte (separate) or lower byte (strobe).
// [R13] Static style input picks separate strobes or data strobe with direction.
// [R14] Data lines float whenever no read is in progress.
`timescale 1ns/1ps
module hpbp_port
  import hpbp_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] register_address_lines,
  input wire logic [DATA_W-1:0] host_data_lines_in,
  output logic [DATA_W-1:0] host_data_lines_out,
  output logic [DATA_W-1:0] host_data_lines_oe,
  input wire logic address_latch_strobe,
  input wire logic device_select_n,
  input wire logic read_or_data_strobe_n,
  input wire logic write_or_direction,
  input wire logic byte_lane_enable_n,
  input wire logic bus_width_select,
  input wire logic interface_style_select,
  output logic [WADDR_W-1:0] reg_word_addr,
  output logic [1:0] reg_byte_en,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr_strobe,
  output logic reg_rd_strobe,
  input wire logic [DATA_W-1:0] reg_rdata
);
  logic [SYNC_W-1:0] pins_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic ale_s;
  logic cs_n_s;
  logic strobe_n_s;
  logic wr_dir_s;
  logic lane_n_s;
  logic wide_s;
  logic style_s;

  hpbp_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d({register_address_lines, host_data_lines_in, address_latch_strobe, device_select_n,
        read_or_data_strobe_n, write_or_direction, byte_lane_enable_n, bus_width_select,
        interface_style_select}),
    .q(pins_s)
  );

  assign {addr_s, data_s, ale_s, cs_n_s, strobe_n_s, wr_dir_s, lane_n_s, wide_s, style_s} = pins_s;

  hpbp_state_t state;
  hpbp_state_t next_state;
  logic ale_prev;
  logic [ADDR_W-1:0] addr_prev;
  logic [ADDR_W-1:0] ale_addr;
  logic muxed_seen;
  logic [ADDR_W-1:0] acc_addr;
  logic [1:0] acc_be;
  logic acc_wide;
  logic [DATA_W-1:0] dout;
  logic [1:0] oe_lanes;

  // Address path: latch on the strobe's falling edge; with a static strobe the
  // address lines are used live, so a tied-high or tied-low strobe both work
  wire ale_fall = ale_prev && !ale_s; // R5
  wire [ADDR_W-1:0] addr_eff = muxed_seen ? ale_addr : addr_s; // R5 R6

  // Handshake decode for both styles; read takes priority if both appear
  wire selected = !cs_n_s; // R9
  wire strobe_on = !strobe_n_s;
  wire sep_rd = strobe_on; // R10
  wire sep_wr = !wr_dir_s; // R11
  wire dstrobe_rd = strobe_on && wr_dir_s;
  wire dstrobe_wr = strobe_on && !wr_dir_s;
  wire rd_act = selected && ((style_s == STYLE_SEPARATE) ? sep_rd : dstrobe_rd); // R13
  wire wr_act = selected && !rd_act && ((style_s == STYLE_SEPARATE) ? sep_wr : dstrobe_wr); // R13

  // Lane selection at the start of an access
  wire addr_odd = addr_eff[0];
  wire lane_on = !lane_n_s;
  wire lane_lo_w = (style_s == STYLE_SEPARATE) ? !addr_odd : lane_on; // R3 R12
  wire lane_hi_w = (style_s == STYLE_SEPARATE) ? lane_on : !addr_odd; // R3 R12
  // Narrow mode: even byte is the low lane in separate style, high lane otherwise
  wire [1:0] lanes_narrow = (addr_odd ^ style_s) ? LANE_HI : LANE_LO; // R1 R8
  wire [1:0] lanes = wide_s ? {lane_hi_w, lane_lo_w} : lanes_narrow; // R2 R3 R8

  // Narrow transfers move the chosen byte to and from the low pin lane
  wire [BYTE_W-1:0] rd_byte = acc_be[1] ? reg_rdata[DATA_W-1:BYTE_W] : reg_rdata[BYTE_W-1:0];
  wire [DATA_W-1:0] rd_steered = acc_wide ? reg_rdata : {{BYTE_W{1'b0}}, rd_byte}; // R1 R2
  wire [DATA_W-1:0] wr_steered = acc_wide ? data_s : {2{data_s[BYTE_W-1:0]}}; // R1 R2
  wire reading = (state == HPBP_RSTART || state == HPBP_READ) && rd_act;
  wire [1:0] pin_lanes = acc_wide ? acc_be : LANE_LO; // R1 R3
  wire [1:0] next_oe_lanes = reading ? pin_lanes : LANE_NONE; // R14

  always_comb begin
    next_state = state;
    unique case (state)
      HPBP_IDLE: begin
        if (rd_act) begin
          next_state = HPBP_RSTART;
        end else if (wr_act) begin
          next_state = HPBP_WRITE;
        end
      end
      HPBP_RSTART: begin
        next_state = rd_act ? HPBP_READ : HPBP_IDLE;
      end
      HPBP_READ: begin
        next_state = rd_act ? HPBP_READ : HPBP_IDLE;
      end
      HPBP_WRITE: begin
        next_state = wr_act ? HPBP_WRITE : HPBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ale_prev <= 1'b0;
      addr_prev <= ADDR_RST;
      ale_addr <= ADDR_RST;
      muxed_seen <= 1'b0;
    end else begin
      ale_prev <= ale_s;
      addr_prev <= addr_s;
      if (ale_fall) begin
        ale_addr <= addr_prev; // R5
        muxed_seen <= 1'b1;
      end
    end
  end

  // Access context is frozen at the start so the address holds throughout
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= HPBP_IDLE;
      acc_addr <= ADDR_RST;
      acc_be <= LANE_NONE;
      acc_wide <= 1'b0;
    end else begin
      state <= next_state;
      if (state == HPBP_IDLE && (rd_act || wr_act)) begin
        acc_addr <= addr_eff; // R5 R7
        acc_be <= lanes; // R3 R8
        acc_wide <= wide_s;
      end
    end
  end

  // Write data follows the bus and is committed when the strobe ends,
  // since hosts guarantee data setup against the trailing edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_wdata <= DATA_RST;
    end else if (state == HPBP_WRITE) begin
      reg_wdata <= wr_steered; // R11
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout <= DATA_RST;
      oe_lanes <= LANE_NONE;
    end else begin
      oe_lanes <= next_oe_lanes; // R14
      if (reading) begin
        dout <= rd_steered; // R10
      end
    end
  end

  assign reg_word_addr = acc_addr[ADDR_W-1:1]; // R7
  assign reg_byte_en = acc_be; // R8
  assign reg_rd_strobe = (state == HPBP_RSTART); // R10
  assign reg_wr_strobe = (state == HPBP_WRITE) && !wr_act; // R11
  assign host_data_lines_out = dout;
  assign host_data_lines_oe = {{BYTE_W{oe_lanes[1]}}, {BYTE_W{oe_lanes[0]}}}; // R1 R2 R14

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  upper_float_narrow_a: assert property (host_data_lines_oe != 16'h0000 && !acc_wide // R1
      |-> host_data_lines_oe == 16'h00ff)
    else $error("upper byte driven in narrow mode");
  word_read_drive_a: assert property (state == HPBP_READ && rd_act && acc_wide // R2
      && acc_be == LANE_BOTH |=> host_data_lines_oe == 16'hffff)
    else $error("word read not driven on all lines");
  lane_choice_a: assert property (state == HPBP_IDLE && rd_act && wide_s // R3
      && style_s == STYLE_SEPARATE && addr_odd && lane_on |=> acc_be == LANE_HI)
    else $error("wrong lane for separate style upper byte");
  strobe_lane_a: assert property (state == HPBP_IDLE && wr_act && wide_s // R12
      && style_s == STYLE_DATA_STROBE && addr_odd && lane_on |=> acc_be == LANE_LO)
    else $error("wrong lane for data strobe lower byte");
  addr_capture_a: assert property (ale_fall |=> ale_addr == $past(addr_prev) && muxed_seen) // R5
    else $error("address not captured at strobe fall");
  addr_hold_a: assert property (state != HPBP_IDLE && $past(state) != HPBP_IDLE // R5
      |-> $stable(acc_addr))
    else $error("address changed during access");
  single_target_a: assert property (state == HPBP_IDLE && (rd_act || wr_act) // R7
      |=> reg_word_addr == $past(addr_eff[ADDR_W-1:1]) && !(reg_rd_strobe && reg_wr_strobe))
    else $error("access targets more than one register");
  read_data_a: assert property (reading |=> host_data_lines_out == $past(rd_steered) // R10
      && host_data_lines_oe != 16'h0000 || $past(acc_be) == LANE_NONE)
    else $error("read data not presented");
  write_commit_a: assert property (state == HPBP_WRITE && wr_act ##1 !wr_act // R11
      |-> reg_wr_strobe ##1 !reg_wr_strobe && state == HPBP_IDLE)
    else $error("write not committed once at strobe end");
  idle_float_a: assert property (!reading |=> host_data_lines_oe == 16'h0000) // R14
    else $error("data lines driven outside a read");
  deselect_ignore_a: assert property (state == HPBP_IDLE && cs_n_s // R9
      |=> state == HPBP_IDLE && !reg_rd_strobe)
    else $error("access started while deselected");

  word_read_c: cover property (state == HPBP_READ && acc_wide && acc_be == LANE_BOTH);
  narrow_write_c: cover property (reg_wr_strobe && !acc_wide);
  muxed_read_c: cover property (ale_fall ##[1:20] reg_rd_strobe);
  strobe_style_c: cover property (reg_wr_strobe && style_s == STYLE_DATA_STROBE);
endmodule : hpbp_port

// ==== tb/hpbp_host_model.sv ====
// Host processor model that drives the port's pins
`timescale 1ns/1ps
module hpbp_host_model
  import hpbp_pkg::*;
(
  input wire logic core_clk,
  output logic [ADDR_W-1:0] register_address_lines,
  output logic [DATA_W-1:0] host_data_lines_in,
  input wire logic [DATA_W-1:0] host_data_lines_out,
  input wire logic [DATA_W-1:0] host_data_lines_oe,
  output logic address_latch_strobe,
  output logic device_select_n,
  output logic read_or_data_strobe_n,
  output logic write_or_direction,
  output logic byte_lane_enable_n
);
  logic drv_en = 1'b0;
  logic [DATA_W-1:0] drv = 16'h0000;
  // Undriven lines read back inverted so a stale value cannot pass
  assign host_data_lines_in = host_data_lines_oe & host_data_lines_out
    | ~host_data_lines_oe & (drv_en ? drv : ~drv);
  initial begin
    register_address_lines = 10'h000;
    address_latch_strobe = 1'b0;
    device_select_n = 1'b1;
    read_or_data_strobe_n = 1'b1;
    write_or_direction = 1'b1;
    byte_lane_enable_n = 1'b1;
  end
  task automatic access(input logic st, input logic wr, input logic [ADDR_W-1:0] a,
      input logic ln, input logic [DATA_W-1:0] wd, input logic sel_n, input logic mux,
      output logic [DATA_W-1:0] rd, output logic [DATA_W-1:0] oe);
    @(negedge core_clk);
    register_address_lines = a;
    address_latch_strobe = mux;
    if (mux) begin
      repeat (2) @(negedge core_clk);
      address_latch_strobe = 1'b0;
      @(negedge core_clk);
      register_address_lines = ~a;
    end
    device_select_n = sel_n;
    byte_lane_enable_n = ln;
    drv = wd;
    drv_en = wr;
    write_or_direction = ~wr;
    read_or_data_strobe_n = (st == STYLE_SEPARATE) & wr;
    // Sample at a falling edge, clear of the edge that launches the outputs
    repeat (8) @(negedge core_clk);
    rd = host_data_lines_in;
    oe = host_data_lines_oe;
    read_or_data_strobe_n = 1'b1;
    write_or_direction = 1'b1;
    device_select_n = 1'b1;
    byte_lane_enable_n = 1'b1;
    drv_en = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : access
endmodule : hpbp_host_model

// ==== tb/test_host_parallel_bus_port.sv ====
// Self-checking bench for the host parallel bus port
`timescale 1ns/1ps
module test_host_parallel_bus_port
  import hpbp_pkg::*;
;
  logic core_clk, arst_n, bus_width_select, interface_style_select;
  logic [ADDR_W-1:0] register_address_lines;
  logic [DATA_W-1:0] host_data_lines_in, host_data_lines_out, host_data_lines_oe;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd, oe;
  logic address_latch_strobe, device_select_n, read_or_data_strobe_n;
  logic write_or_direction, byte_lane_enable_n, reg_wr_strobe, reg_rd_strobe;
  logic [WADDR_W-1:0] reg_word_addr;
  logic [1:0] reg_byte_en;
  logic [DATA_W-1:0] mem [0:(1<<WADDR_W)-1];
  int n_errors = 0;
  int n_compared = 0;
  int n_rd_pulses = 0;
  hpbp_port i_dut (.core_clk, .arst_n, .register_address_lines, .host_data_lines_in,
    .host_data_lines_out, .host_data_lines_oe, .address_latch_strobe, .device_select_n,
    .read_or_data_strobe_n, .write_or_direction, .byte_lane_enable_n, .bus_width_select,
    .interface_style_select, .reg_word_addr, .reg_byte_en, .reg_wdata, .reg_wr_strobe,
    .reg_rd_strobe, .reg_rdata);
  hpbp_host_model i_host (.core_clk, .register_address_lines, .host_data_lines_in,
    .host_data_lines_out, .host_data_lines_oe, .address_latch_strobe, .device_select_n,
    .read_or_data_strobe_n, .write_or_direction, .byte_lane_enable_n);
  // Register fabric stand-in: word array with byte enables
  assign reg_rdata = mem[reg_word_addr];
  always @(posedge core_clk) begin
    if (reg_wr_strobe && reg_byte_en[0]) mem[reg_word_addr][7:0] <= reg_wdata[7:0];
    if (reg_wr_strobe && reg_byte_en[1]) mem[reg_word_addr][15:8] <= reg_wdata[15:8];
    // Read-start pulses matter for registers with read side effects
    if (reg_rd_strobe) n_rd_pulses++;
  end
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic st, input logic wr, input logic [ADDR_W-1:0] a,
      input logic ln, input logic [DATA_W-1:0] wd, input logic sel_n, input logic mux);
    @(negedge core_clk);
    interface_style_select = st;
    i_host.access(st, wr, a, ln, wd, sel_n, mux, rd, oe);
  endtask : xfer
  task automatic rd_chk(input logic st, input logic [ADDR_W-1:0] a, input logic ln,
      input logic [DATA_W-1:0] exp_d, input logic [DATA_W-1:0] exp_oe, input logic mux);
    int pulses;
    pulses = n_rd_pulses;
    xfer(st, 1'b0, a, ln, 16'h0000, 1'b0, mux);
    check(oe, exp_oe);
    check(rd & exp_oe, exp_d & exp_oe);
    check(host_data_lines_oe, 16'h0000);
    check(16'(n_rd_pulses - pulses), 16'h0001);
  endtask : rd_chk
  task automatic sc_word();
    bus_width_select = 1'b1;
    xfer(STYLE_SEPARATE, 1'b1, 10'h020, 1'b0, 16'h5aa5, 1'b0, 1'b0);
    check(oe, 16'h0000);
    rd_chk(STYLE_SEPARATE, 10'h020, 1'b0, 16'h5aa5, 16'hffff, 1'b0);
    check(16'(reg_word_addr), 16'h0010);
    xfer(STYLE_DATA_STROBE, 1'b1, 10'h062, 1'b0, 16'h1234, 1'b0, 1'b0);
    rd_chk(STYLE_DATA_STROBE, 10'h062, 1'b0, 16'h1234, 16'hffff, 1'b0);
  endtask : sc_word
  task automatic sc_narrow();
    bus_width_select = 1'b0;
    xfer(STYLE_SEPARATE, 1'b1, 10'h040, 1'b1, 16'h003c, 1'b0, 1'b0);
    rd_chk(STYLE_SEPARATE, 10'h040, 1'b1, 16'h003c, 16'h00ff, 1'b0);
    rd_chk(STYLE_SEPARATE, 10'h041, 1'b1, 16'h00e3, 16'h00ff, 1'b0);
    // Upper pins carry junk here: a narrow port must ignore them
    xfer(STYLE_DATA_STROBE, 1'b1, 10'h042, 1'b1, 16'h5ba6, 1'b0, 1'b0);
    rd_chk(STYLE_DATA_STROBE, 10'h042, 1'b1, 16'h00a6, 16'h00ff, 1'b0);
    rd_chk(STYLE_DATA_STROBE, 10'h043, 1'b1, 16'h0021, 16'h00ff, 1'b0);
  endtask : sc_narrow
  task automatic sc_lanes();
    bus_width_select = 1'b1;
    rd_chk(STYLE_SEPARATE, 10'h060, 1'b1, 16'h0030, 16'h00ff, 1'b0);
    rd_chk(STYLE_SEPARATE, 10'h061, 1'b0, 16'hf300, 16'hff00, 1'b0);
    rd_chk(STYLE_DATA_STROBE, 10'h060, 1'b1, 16'hf300, 16'hff00, 1'b0);
    rd_chk(STYLE_DATA_STROBE, 10'h061, 1'b0, 16'h0030, 16'h00ff, 1'b0);
    rd_chk(STYLE_SEPARATE, 10'h061, 1'b1, 16'h0000, 16'h0000, 1'b0);
    xfer(STYLE_DATA_STROBE, 1'b1, 10'h061, 1'b0, 16'h0077, 1'b0, 1'b0);
    rd_chk(STYLE_DATA_STROBE, 10'h060, 1'b0, 16'hf377, 16'hffff, 1'b0);
  endtask : sc_lanes
  task automatic sc_deselect();
    int pulses;
    pulses = n_rd_pulses;
    xfer(STYLE_SEPARATE, 1'b1, 10'h020, 1'b0, 16'hdead, 1'b1, 1'b0);
    xfer(STYLE_SEPARATE, 1'b0, 10'h020, 1'b0, 16'h0000, 1'b1, 1'b0);
    check(oe, 16'h0000);
    check(16'(n_rd_pulses - pulses), 16'h0000);
    rd_chk(STYLE_SEPARATE, 10'h020, 1'b0, 16'h5aa5, 16'hffff, 1'b0);
  endtask : sc_deselect
  task automatic sc_mux();
    // Mux mode is sticky after the first latch strobe, so this runs last
    rd_chk(STYLE_SEPARATE, 10'h0a0, 1'b0, 16'h9350, 16'hffff, 1'b1);
  endtask : sc_mux
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    bus_width_select = 1'b1;
    interface_style_select = STYLE_SEPARATE;
    for (int i = 0; i < (1 << WADDR_W); i++) mem[i] = {i[7:0] ^ 8'hc3, i[7:0]};
    // Count rising edges: the clock's first step from unknown to low is no real cycle
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    sc_word();
    sc_narrow();
    sc_lanes();
    sc_deselect();
    sc_mux();
    print_verdict();
  end
endmodule : test_host_parallel_bus_port
